// File: design/adcc_top.sv
// Conversion control, register file and pin logic of the 10-bit converter
//
// Behaviour
// - Conversion lasts twelve bit periods minimum.
// - Clock select picks 2, 8, 32 or RC.
// - RC bit period nominally four microseconds.
// - Analog pins read as zero on ports.
// - Output-direction pin converts its driven level.
// - Clearing go aborts, result pair unchanged.
// - Abort waits two bit periods, then acquires; switching the converter off skips the wait.
// - First segment between instruction cycle and period.
// - Result justified by format bit, zero filled.
// - Result registers are plain storage otherwise.
// - Sleep needs RC; RC start delayed one instruction cycle.
// - Sleep completion wakes or powers converter down.
// - Non-RC sleep aborts and powers down converter.
// - Reset clears control, aborts, pins analog.
// - Reset never touches the result pair.
// - Completion loads result, clears go, sets flag.
// - Two bit periods pass before new acquisition.
`default_nettype none
module adcc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire adcc_pkg::adcc_bus_t bus_req,
  output logic [7:0] rdata,
  // Power state
  input wire logic sleep_mode,
  output logic wake_req,
  // Analog front end
  input wire logic [9:0] conv_sample,
  output logic [2:0] chan_sel,
  output logic hold_connect,
  output logic conv_powered,
  // Port pins
  input wire logic [5:0] port_a_in,
  output logic [5:0] port_a_out,
  output logic [5:0] port_a_oe,
  input wire logic [2:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  adcc_pkg::adcc_state_t state;
  adcc_pkg::adcc_state_t next_state;
  adcc_pkg::adcc_clk_sel_t conv_clk_sel;
  logic conv_go;
  logic conv_module_on;
  logic result_format_sel;
  logic [3:0] pin_analog_cfg;
  logic [7:0] global_irq_control;
  logic [7:0] irq_flags;
  logic [7:0] irq_enables;
  logic [7:0] conversion_result_high;
  logic [7:0] conversion_result_low;
  logic pwr_down;
  logic [8:0] tad_cnt;
  logic [8:0] tad_len;
  logic [8:0] seg_len;
  logic [3:0] seg_cnt;
  logic tad_tick;
  logic busy;
  logic abort;
  logic sleep_abort;
  logic done_evt;
  logic [7:0] analog_inputs;
  logic [7:0] ch_oe;
  logic [7:0] ch_lvl;
  logic [9:0] raw_result;
  logic [15:0] justified;
  logic [7:0] next_rdata;
  logic wr_ctrl0;
  logic wr_flags;
  logic wr_res_hi;
  logic wr_res_lo;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin configuration decode, one bit per analog input, reference pins counted
  function automatic logic [7:0] analog_mask(input logic [3:0] cfg);
    case (cfg)
      4'h0, 4'h1, 4'h8: analog_mask = 8'hff;
      4'h2, 4'h3, 4'hc: analog_mask = 8'h1f;
      4'h4, 4'h5: analog_mask = 8'h0b;
      4'h9, 4'ha, 4'hb: analog_mask = 8'h3f;
      4'hd: analog_mask = 8'h0f;
      4'he: analog_mask = 8'h01;
      4'hf: analog_mask = 8'h0d;
      default: analog_mask = 8'h00;
    endcase
  endfunction

  assign analog_inputs = analog_mask(pin_analog_cfg);
  // Inputs 0-3 sit on port A 0-3, input 4 on port A 5, inputs 5-7 on port E
  assign ch_oe = {port_e_oe, port_a_oe[5], port_a_oe[3:0]};
  assign ch_lvl = {port_e_out, port_a_out[5], port_a_out[3:0]};
  // Driven output pin converts as full or zero scale
  assign raw_result = ch_oe[chan_sel] ? {10{ch_lvl[chan_sel]}} : conv_sample;
  assign justified = result_format_sel ? {6'h00, raw_result} : {raw_result, 6'h00};

  ////////////////////////////////////////////////////////////////////////////////
  // Register strobes
  assign wr_ctrl0 = bus_req.wr && (bus_req.addr == adcc_pkg::ADDR_CTRL0);
  assign wr_flags = bus_req.wr && (bus_req.addr == adcc_pkg::ADDR_FLAGS);
  assign wr_res_hi = bus_req.wr && (bus_req.addr == adcc_pkg::ADDR_RES_HI);
  assign wr_res_lo = bus_req.wr && (bus_req.addr == adcc_pkg::ADDR_RES_LO);

  ////////////////////////////////////////////////////////////////////////////////
  // Bit period timing
  always_comb begin
    case (conv_clk_sel)
      adcc_pkg::ADCC_CLK_DIV2: tad_len = adcc_pkg::TAD_DIV2;
      adcc_pkg::ADCC_CLK_DIV8: tad_len = adcc_pkg::TAD_DIV8;
      adcc_pkg::ADCC_CLK_DIV32: tad_len = adcc_pkg::TAD_DIV32;
      default: tad_len = adcc_pkg::TAD_RC;
    endcase
  end

  // RC start waits one instruction cycle; others wait one bit period
  assign seg_len = (state == adcc_pkg::ADCC_ST_FIRST && conv_clk_sel == adcc_pkg::ADCC_CLK_RC) ?
                   adcc_pkg::TCY_CYC : tad_len;
  // At-or-past compare so a clock select change mid-period cannot skip the tick
  assign tad_tick = (state != adcc_pkg::ADCC_ST_IDLE) && (tad_cnt >= seg_len - 9'h001);
  assign busy = (state == adcc_pkg::ADCC_ST_FIRST) || (state == adcc_pkg::ADCC_ST_CONV);
  // Only the RC source keeps running through sleep
  assign sleep_abort = busy && sleep_mode && (conv_clk_sel != adcc_pkg::ADCC_CLK_RC);
  assign abort = busy && (!conv_go || !conv_module_on || sleep_abort);
  assign done_evt = (state == adcc_pkg::ADCC_ST_CONV) && tad_tick &&
                    (seg_cnt == adcc_pkg::CONV_LAST) && !abort;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tad_cnt <= 9'h000;
    end else if (state == adcc_pkg::ADCC_ST_IDLE || next_state != state || tad_tick) begin
      tad_cnt <= 9'h000;
    end else begin
      tad_cnt <= tad_cnt + 9'h001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seg_cnt <= 4'h0;
    end else if (next_state != state) begin
      seg_cnt <= 4'h0;
    end else if (tad_tick) begin
      seg_cnt <= seg_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_comb begin
    next_state = state;
    case (state)
      adcc_pkg::ADCC_ST_IDLE: begin
        if (conv_go && conv_module_on && !pwr_down) begin
          next_state = adcc_pkg::ADCC_ST_FIRST;
        end
      end
      adcc_pkg::ADCC_ST_FIRST: begin
        if (abort) begin
          next_state = adcc_pkg::ADCC_ST_WAIT;
        end else if (tad_tick) begin
          next_state = adcc_pkg::ADCC_ST_CONV;
        end
      end
      adcc_pkg::ADCC_ST_CONV: begin
        if (abort || done_evt) begin
          next_state = adcc_pkg::ADCC_ST_WAIT;
        end
      end
      adcc_pkg::ADCC_ST_WAIT: begin
        if (!conv_module_on || (tad_tick && seg_cnt == adcc_pkg::POST_LAST)) begin
          next_state = adcc_pkg::ADCC_ST_IDLE;
        end
      end
      default: next_state = adcc_pkg::ADCC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= adcc_pkg::ADCC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_clk_sel <= adcc_pkg::ADCC_CLK_DIV2;
      chan_sel <= 3'h0;
      conv_module_on <= 1'b0;
    end else if (wr_ctrl0) begin
      conv_clk_sel <= adcc_pkg::adcc_clk_sel_t'(bus_req.wdata[adcc_pkg::CTRL0_CLK_LO +: 2]);
      chan_sel <= bus_req.wdata[adcc_pkg::CTRL0_CH_LO +: 3];
      conv_module_on <= bus_req.wdata[adcc_pkg::CTRL0_ON];
    end
  end

  // Hardware clear beats a software write in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_go <= 1'b0;
    end else if (done_evt || sleep_abort) begin
      conv_go <= 1'b0;
    end else if (wr_ctrl0) begin
      conv_go <= bus_req.wdata[adcc_pkg::CTRL0_GO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_format_sel <= 1'b0;
      pin_analog_cfg <= 4'h0;
    end else if (bus_req.wr && bus_req.addr == adcc_pkg::ADDR_CTRL1) begin
      result_format_sel <= bus_req.wdata[adcc_pkg::CTRL1_FMT];
      pin_analog_cfg <= bus_req.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flag, enable and global control storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_flags <= adcc_pkg::IRQ_RST;
    end else begin
      if (wr_flags) begin
        irq_flags <= bus_req.wdata;
      end
      if (done_evt) begin
        irq_flags[adcc_pkg::DONE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_enables <= adcc_pkg::IRQ_RST;
      global_irq_control <= adcc_pkg::IRQ_RST;
    end else begin
      if (bus_req.wr && bus_req.addr == adcc_pkg::ADDR_ENABLES) begin
        irq_enables <= bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == adcc_pkg::ADDR_GIC) begin
        global_irq_control <= bus_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result pair, no reset so its content survives every reset
  always_ff @(posedge mclk) begin
    if (done_evt) begin
      conversion_result_high <= justified[15:8];
      conversion_result_low <= justified[7:0];
    end else begin
      if (wr_res_hi) begin
        conversion_result_high <= bus_req.wdata;
      end
      if (wr_res_lo) begin
        conversion_result_low <= bus_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep handling and converter power
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_down <= 1'b0;
    end else if (!sleep_mode) begin
      pwr_down <= 1'b0;
    end else if (sleep_abort) begin
      pwr_down <= 1'b1;
    end else if (done_evt && !irq_enables[adcc_pkg::DONE_BIT]) begin
      pwr_down <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
      conv_powered <= 1'b0;
      hold_connect <= 1'b0;
    end else begin
      wake_req <= done_evt && sleep_mode && irq_enables[adcc_pkg::DONE_BIT];
      conv_powered <= conv_module_on && !pwr_down;
      // Hold capacitor is off the channel from start until the post wait ends
      hold_connect <= (state == adcc_pkg::ADCC_ST_IDLE) && conv_module_on && !pwr_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port latches and directions, enables stored as inverse of direction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_a_out <= 6'h00;
      port_e_out <= 3'h0;
      port_a_oe <= ~adcc_pkg::DIR_A_RST;
      port_e_oe <= ~adcc_pkg::DIR_E_RST;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        adcc_pkg::ADDR_PORT_A: port_a_out <= bus_req.wdata[5:0];
        adcc_pkg::ADDR_PORT_E: port_e_out <= bus_req.wdata[2:0];
        adcc_pkg::ADDR_DIR_A: port_a_oe <= ~bus_req.wdata[5:0];
        adcc_pkg::ADDR_DIR_E: port_e_oe <= ~bus_req.wdata[2:0];
        default: port_a_out <= port_a_out;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    next_rdata = 8'h00;
    case (bus_req.addr)
      adcc_pkg::ADDR_PORT_A: begin
        next_rdata = {2'h0, port_a_in & ~{analog_inputs[4], 1'b0, analog_inputs[3:0]}};
      end
      adcc_pkg::ADDR_PORT_E: next_rdata = {5'h00, port_e_in & ~analog_inputs[7:5]};
      adcc_pkg::ADDR_GIC: next_rdata = global_irq_control;
      adcc_pkg::ADDR_FLAGS: next_rdata = irq_flags;
      adcc_pkg::ADDR_RES_HI: next_rdata = conversion_result_high;
      adcc_pkg::ADDR_CTRL0: begin
        next_rdata = {conv_clk_sel, chan_sel, conv_go, 1'b0, conv_module_on};
      end
      adcc_pkg::ADDR_DIR_A: next_rdata = {2'h0, ~port_a_oe};
      adcc_pkg::ADDR_DIR_E: next_rdata = {5'h00, ~port_e_oe};
      adcc_pkg::ADDR_ENABLES: next_rdata = irq_enables;
      adcc_pkg::ADDR_RES_LO: next_rdata = conversion_result_low;
      adcc_pkg::ADDR_CTRL1: next_rdata = {result_format_sel, 3'h0, pin_analog_cfg};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= bus_req.rd ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  int conv_cyc;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_cyc <= 0;
    end else begin
      conv_cyc <= (state == adcc_pkg::ADCC_ST_CONV) ? conv_cyc + 1 : 0;
    end
  end

  property p_conv_len;
    done_evt && $stable(conv_clk_sel) |-> conv_cyc + 1 >= adcc_pkg::CONV_TADS * int'(tad_len);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion shorter than 12 periods");

  property p_div8_period;
    state == adcc_pkg::ADCC_ST_CONV && tad_tick && conv_clk_sel == adcc_pkg::ADCC_CLK_DIV8 &&
    !wr_ctrl0 |=> (!tad_tick || state != adcc_pkg::ADCC_ST_CONV)[*7];
  endproperty
  a_div8_period: assert property (p_div8_period) else $error("divide-by-8 period too short");

  property p_abort_keeps;
    state == adcc_pkg::ADCC_ST_CONV && abort && !wr_res_hi && !wr_res_lo
    |=> $stable(conversion_result_high) && $stable(conversion_result_low);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");

  property p_abort_wait;
    abort && conv_module_on |=> state == adcc_pkg::ADCC_ST_WAIT ##1
    (state == adcc_pkg::ADCC_ST_WAIT)[*3];
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("no post-abort wait");

  property p_rc_first;
    state == adcc_pkg::ADCC_ST_FIRST && $past(state) == adcc_pkg::ADCC_ST_IDLE &&
    conv_clk_sel == adcc_pkg::ADCC_CLK_RC |-> ##4 state != adcc_pkg::ADCC_ST_FIRST;
  endproperty
  a_rc_first: assert property (p_rc_first) else $error("RC start delay wrong");

  property p_done;
    done_evt |=> irq_flags[adcc_pkg::DONE_BIT] && !conv_go && state == adcc_pkg::ADCC_ST_WAIT;
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing");

  property p_flag_cause;
    !irq_flags[adcc_pkg::DONE_BIT] ##1 irq_flags[adcc_pkg::DONE_BIT]
    |-> $past(done_evt) || ($past(wr_flags) && $past(bus_req.wdata[adcc_pkg::DONE_BIT]));
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without completion");

  property p_sleep_abort;
    sleep_abort && !wr_ctrl0 |-> ##2 !conv_powered && conv_module_on;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort kept power");

  property p_wake;
    done_evt && sleep_mode && irq_enables[adcc_pkg::DONE_BIT] |=> wake_req ##1 conv_powered;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on sleep completion");

  property p_port_analog;
    bus_req.rd && bus_req.addr == adcc_pkg::ADDR_PORT_E
    |=> (rdata[2:0] & $past(analog_inputs[7:5])) == 3'h0;
  endproperty
  a_port_analog: assert property (p_port_analog) else $error("analog pin read nonzero");

  c_done: cover property (done_evt);
  c_abort: cover property (state == adcc_pkg::ADCC_ST_CONV && abort);
  c_sleep_wake: cover property (done_evt && sleep_mode ##1 wake_req);
endmodule
`default_nettype wire

// File: design/adcc_pkg.sv
// Constants, types and register map of the converter control block
`default_nettype none
package adcc_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_PORT_A = 8'h05;
  localparam logic [7:0] ADDR_PORT_E = 8'h09;
  localparam logic [7:0] ADDR_GIC = 8'h0b;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_RES_HI = 8'h1e;
  localparam logic [7:0] ADDR_CTRL0 = 8'h1f;
  localparam logic [7:0] ADDR_DIR_A = 8'h85;
  localparam logic [7:0] ADDR_DIR_E = 8'h89;
  localparam logic [7:0] ADDR_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_RES_LO = 8'h9e;
  localparam logic [7:0] ADDR_CTRL1 = 8'h9f;
  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL0_CLK_LO = 6;
  localparam int CTRL0_CH_LO = 3;
  localparam int CTRL0_GO = 2;
  localparam int CTRL0_ON = 0;
  localparam int CTRL1_FMT = 7;
  localparam int DONE_BIT = 6;
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [5:0] DIR_A_RST = 6'h3f;
  localparam logic [2:0] DIR_E_RST = 3'h7;
  ////////////////////////////////////////////////////////////////////////////////
  // Conversion clock and timing
  typedef enum logic [1:0] {
    ADCC_CLK_DIV2 = 2'h0,
    ADCC_CLK_DIV8 = 2'h1,
    ADCC_CLK_DIV32 = 2'h2,
    ADCC_CLK_RC = 2'h3
  } adcc_clk_sel_t;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_TAD_NS = 4000;
  localparam logic [8:0] TAD_DIV2 = 9'h002;
  localparam logic [8:0] TAD_DIV8 = 9'h008;
  localparam logic [8:0] TAD_DIV32 = 9'h020;
  localparam logic [8:0] TAD_RC = 9'(RC_TAD_NS / CLK_PERIOD_NS);
  localparam logic [8:0] TCY_CYC = 9'h004;
  localparam int CONV_TADS = 12;
  localparam logic [3:0] CONV_LAST = 4'(CONV_TADS - 1);
  localparam logic [3:0] POST_LAST = 4'h1;
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [3:0] {
    ADCC_ST_IDLE = 4'b0001,
    ADCC_ST_FIRST = 4'b0010,
    ADCC_ST_CONV = 4'b0100,
    ADCC_ST_WAIT = 4'b1000
  } adcc_state_t;
  ////////////////////////////////////////////////////////////////////////////////
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcc_bus_t;
endpackage
`default_nettype wire

// File: dv/test_adc_conversion_control.sv
// Self-checking bench of the converter control block
`default_nettype none
module test_adc_conversion_control;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  logic mclk;
  logic rst;
  adcc_pkg::adcc_bus_t bus_req;
  logic [7:0] rdata;
  logic sleep_mode;
  logic wake_req;
  logic [9:0] conv_sample;
  logic [2:0] chan_sel;
  logic hold_connect;
  logic conv_powered;
  logic [5:0] port_a_in;
  logic [5:0] port_a_out;
  logic [5:0] port_a_oe;
  logic [2:0] port_e_in;
  logic [2:0] port_e_out;
  logic [2:0] port_e_oe;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wakes = 0;
  int w0;
  logic [7:0] d;
  // Bit period in clock cycles for each clock select code
  int tads[4] = '{2, 8, 32, adcc_pkg::RC_TAD_NS / 10};
  logic [7:0] raddr[8] = '{adcc_pkg::ADDR_CTRL0, adcc_pkg::ADDR_CTRL1, adcc_pkg::ADDR_DIR_A,
    adcc_pkg::ADDR_DIR_E, adcc_pkg::ADDR_FLAGS, adcc_pkg::ADDR_ENABLES, 8'h40,
    adcc_pkg::ADDR_GIC};
  logic [7:0] rexp[8] = '{8'h00, 8'h00, 8'h3f, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};

  adcc_top dut_u (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .sleep_mode(sleep_mode), .wake_req(wake_req),
    .conv_sample(conv_sample), .chan_sel(chan_sel),
    .hold_connect(hold_connect), .conv_powered(conv_powered),
    .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .port_e_in(port_e_in), .port_e_out(port_e_out), .port_e_oe(port_e_oe)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cycle count, wake pulse count and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) begin
      wakes <= wakes + 1;
    end
    if (cyc == 40000) begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [7:0] v;
    bus_rd(a, v);
    chk({8'h00, v}, {8'h00, e}, m);
  endtask

  // One full conversion; pin=1 expects full scale from a pin the caller drives high as an output
  task automatic convert(input logic [1:0] cs, input logic fmt, input logic [2:0] ch,
                         input logic slp, input logic pin);
    time t0;
    int el;
    int lim;
    logic [9:0] s;
    logic [7:0] hi;
    logic [7:0] lo;
    lim = ((cs == 2'h3) ? 4 : tads[cs]) + 12 * tads[cs];
    s = pin ? 10'h3ff : 10'($urandom);
    conv_sample <= pin ? 10'h000 : s;
    bus_wr(adcc_pkg::ADDR_CTRL1, {fmt, 7'h00});
    bus_wr(adcc_pkg::ADDR_FLAGS, 8'h00);
    bus_wr(adcc_pkg::ADDR_CTRL0, {cs, ch, 3'h1});
    bus_wr(adcc_pkg::ADDR_CTRL0, {cs, ch, 3'h5});
    t0 = $time;
    sleep_mode <= slp;
    hi = 8'h04;
    for (int i = 0; i < 3000 && hi[2] !== 1'b0; i++) bus_rd(adcc_pkg::ADDR_CTRL0, hi);
    el = int'(($time - t0) / 10);
    chk({15'h0000, el >= lim && el <= lim + 8}, 16'h0001, "conv time");
    chk({8'h00, hi}, {8'h00, cs, ch, 3'h1}, "go cleared, on kept");
    chk({13'h0000, chan_sel}, {13'h0000, ch}, "channel select");
    bus_rd(adcc_pkg::ADDR_RES_HI, hi);
    bus_rd(adcc_pkg::ADDR_RES_LO, lo);
    chk({hi, lo}, fmt ? {6'h00, s} : {s, 6'h00}, "result");
    rd_chk(adcc_pkg::ADDR_FLAGS, 8'h40, "done flag");
    // Let the post-conversion wait run out before the next start
    repeat (2 * tads[cs] + 2) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    bus_req = '0;
    sleep_mode = 1'b0;
    conv_sample = 10'h000;
    port_a_in = 6'h00;
    port_e_in = 3'h0;
    void'($urandom(32'h858d_628f));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({10'h000, port_a_oe}, 16'h0000, "oe at reset");
    foreach (raddr[i]) rd_chk(raddr[i], rexp[i], "reset value");
    // Result pair and direction registers as storage
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      bus_wr(adcc_pkg::ADDR_RES_HI, d);
      rd_chk(adcc_pkg::ADDR_RES_HI, d, "res hi storage");
      bus_wr(adcc_pkg::ADDR_RES_LO, ~d);
      rd_chk(adcc_pkg::ADDR_RES_LO, ~d, "res lo storage");
      bus_wr(adcc_pkg::ADDR_DIR_A, d);
      #1;
      chk({10'h000, port_a_oe}, {10'h000, ~d[5:0]}, "oe from dir");
    end
    bus_wr(adcc_pkg::ADDR_DIR_A, 8'h3f);
    bus_wr(adcc_pkg::ADDR_DIR_E, 8'h02);
    bus_wr(adcc_pkg::ADDR_PORT_E, 8'h05);
    #1;
    chk({13'h0000, port_e_oe}, 16'h0005, "oe from dir e");
    chk({13'h0000, port_e_out}, 16'h0005, "port e latch");
    bus_wr(adcc_pkg::ADDR_DIR_E, 8'h07);
    // Port reads with all analog, then all digital; port A bit 4 is never analog
    port_a_in <= 6'($urandom);
    port_e_in <= 3'($urandom);
    #1;
    rd_chk(adcc_pkg::ADDR_PORT_A, {2'h0, port_a_in & 6'h10}, "analog port a");
    rd_chk(adcc_pkg::ADDR_PORT_E, 8'h00, "analog port e");
    bus_wr(adcc_pkg::ADDR_CTRL1, 8'h06);
    rd_chk(adcc_pkg::ADDR_PORT_A, {2'h0, port_a_in}, "digital port a");
    rd_chk(adcc_pkg::ADDR_PORT_E, {5'h00, port_e_in}, "digital port e");
    // Every clock select, both formats
    for (int c = 0; c < 4; c++) convert(2'(c), c[0], 3'($urandom), 1'b0, 1'b0);
    bus_wr(adcc_pkg::ADDR_DIR_A, 8'h3e);
    bus_wr(adcc_pkg::ADDR_PORT_A, 8'h01);
    #1;
    chk({10'h000, port_a_out}, 16'h0001, "port a latch");
    convert(2'h0, 1'b1, 3'h0, 1'b0, 1'b1);
    bus_wr(adcc_pkg::ADDR_DIR_A, 8'h3f);
    // Sleep conversions on the RC clock, with and without wake enable
    bus_wr(adcc_pkg::ADDR_ENABLES, 8'h40);
    w0 = wakes;
    convert(2'h3, 1'b0, 3'h5, 1'b1, 1'b0);
    repeat (2) @(posedge mclk);
    chk(16'(wakes - w0), 16'h0001, "wake pulse");
    sleep_mode <= 1'b0;
    bus_wr(adcc_pkg::ADDR_ENABLES, 8'h00);
    convert(2'h3, 1'b1, 3'h6, 1'b1, 1'b0);
    chk(16'(wakes - w0), 16'h0001, "no wake when disabled");
    chk({15'h0000, conv_powered}, 16'h0000, "sleep power down");
    sleep_mode <= 1'b0;
    // Sleep on a divided clock aborts
    bus_wr(adcc_pkg::ADDR_FLAGS, 8'h00);
    bus_wr(adcc_pkg::ADDR_RES_HI, 8'h3c);
    bus_wr(adcc_pkg::ADDR_RES_LO, 8'hc3);
    bus_wr(adcc_pkg::ADDR_CTRL0, 8'h91);
    bus_wr(adcc_pkg::ADDR_CTRL0, 8'h95);
    repeat (10) @(posedge mclk);
    sleep_mode <= 1'b1;
    repeat (80) @(posedge mclk);
    #1;
    chk({15'h0000, conv_powered}, 16'h0000, "sleep abort power");
    rd_chk(adcc_pkg::ADDR_CTRL0, 8'h91, "sleep abort ctrl");
    rd_chk(adcc_pkg::ADDR_FLAGS, 8'h00, "no flag on abort");
    sleep_mode <= 1'b0;
    repeat (80) @(posedge mclk);
    #1;
    chk({15'h0000, conv_powered}, 16'h0001, "power back");
    // Software abort mid-conversion, then the two-period wait
    bus_wr(adcc_pkg::ADDR_CTRL0, 8'h51);
    bus_wr(adcc_pkg::ADDR_CTRL0, 8'h55);
    repeat (20) @(posedge mclk);
    bus_wr(adcc_pkg::ADDR_CTRL0, 8'h51);
    repeat (14) @(posedge mclk);
    #1;
    chk({15'h0000, hold_connect}, 16'h0000, "hold during wait");
    repeat (8) @(posedge mclk);
    #1;
    chk({15'h0000, hold_connect}, 16'h0001, "hold after wait");
    rd_chk(adcc_pkg::ADDR_RES_HI, 8'h3c, "abort keeps hi");
    rd_chk(adcc_pkg::ADDR_RES_LO, 8'hc3, "abort keeps lo");
    rd_chk(adcc_pkg::ADDR_FLAGS, 8'h00, "abort no flag");
    // Reset during the first bit period of a conversion
    bus_wr(adcc_pkg::ADDR_CTRL0, 8'h55);
    repeat (5) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(adcc_pkg::ADDR_CTRL0, 8'h00, "ctrl after reset");
    rd_chk(adcc_pkg::ADDR_RES_HI, 8'h3c, "hi after reset");
    rd_chk(adcc_pkg::ADDR_RES_LO, 8'hc3, "lo after reset");
    chk({15'h0000, conv_powered}, 16'h0000, "off after reset");
    finish_test();
  end
endmodule
`default_nettype wire
